/* bench/digital_input_conditioner_tb.sv */
// self-checking bench for the input conditioner
// assumes 200 MHz clock and the fixed 2 ms sample tick
`timescale 1ns/1ps
`include "din_cond_consts.vh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module digital_input_conditioner_tb;
	logic i_clk_sys = 0, i_resetn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_drive_enable_req = 0, err;
	logic [11:0] i_paddr = 0;
	logic [31:0] i_pwdata = 0, rd, seed = 32'h66DF;
	logic [7:0] level = 0, i_din, strb = 0, cond = 0, nc, exp_s;
	int cnt [8] = '{default: 0};
	int err_count = 0, check_count = 0;
	wire o_pready, o_pslverr, o_drive_enable, o_brake_release, o_pos_limit, o_neg_limit, o_home_switch;
	wire o_quickstop_req, o_auto_mode, o_decel_limit_en, o_sample_tick;
	wire [31:0] o_prdata, o_decel_limit;
	wire [7:0] o_func_strobe;
	digital_input_conditioner dut_u (.i_clk_sys, .i_resetn, .i_din, .i_drive_enable_req, .i_psel, .i_penable,
		.i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_prdata, .o_drive_enable, .o_brake_release,
		.o_pos_limit, .o_neg_limit, .o_home_switch, .o_quickstop_req, .o_auto_mode, .o_decel_limit_en,
		.o_decel_limit, .o_func_strobe, .o_sample_tick);
	din_switch_model sw_u (.i_clk_sys(i_clk_sys), .i_level(level), .o_din(i_din));
	function automatic logic [31:0] xs(input logic [31:0] s);
		xs = s ^ (s << 13);
		xs ^= xs >> 17;
		xs ^= xs << 5;
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk_sys) i_penable <= 1;
		do @(posedge i_clk_sys); while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
		@(posedge i_clk_sys);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// strobes last one cycle, so they are gathered here
	always @(posedge i_clk_sys) strb <= strb | o_func_strobe;
	initial forever #2.5 i_clk_sys = ~i_clk_sys;
	initial begin
		#(5.0 * 400000 * 10);
		err_count++;
		finish_test();
	end
	initial begin
		repeat (2) @(posedge i_clk_sys);
		i_resetn <= 1;
		i_drive_enable_req <= 1;
		apb(0, `DC_ADDR_DEB_LO, 0);
		`CHK("deb_lo", `DC_RST_DEB, rd)
		apb(0, 12'h0FC, 0);
		`CHK("unmapped", 33'h100000000, {err, rd})
		// every function code once; input 1 debounce 2, input 3 inverted, input 2 level mode
		apb(1, `DC_ADDR_FUNC_LO, 32'h76543210);
		apb(1, `DC_ADDR_DEB_LO, 32'h01010201);
		apb(1, `DC_ADDR_CTRL, 32'h00000408);
		apb(0, `DC_ADDR_FUNC_LO, 0);
		`CHK("func_lo", 32'h76543210, rd)
		for (int t = 0; t < 5; t++) begin
			seed = xs(seed);
			level <= {seed[7:2], t != 2, seed[0]};
			@(posedge o_sample_tick);
			strb <= 0;
			repeat (4) @(posedge i_clk_sys);
			for (int k = 0; k < 8; k++) begin
				cnt[k] = (level[k] ^ (k == 3)) ? cnt[k] + 1 : 0;
				nc[k] = cnt[k] >= ((k == 1) ? 2 : 1);
				exp_s[k] = (k == 2) ? nc[k] : nc[k] != cond[k];
			end
			cond = nc;
			`CHK("brake", cond[1], o_brake_release)
			`CHK("limits", cond[4:2], {o_home_switch, o_neg_limit, o_pos_limit})
			`CHK("qstop", cond[5] | cond[7], o_quickstop_req)
			`CHK("strobe", exp_s & 8'hFE, strb & 8'hFE)
			`CHK("enable", level[0], o_drive_enable)
			`CHK("decel", `DC_RST_QSDEC, o_decel_limit)
			`CHK("decel_en", cond[5] | cond[7], o_decel_limit_en)
			`CHK("auto", cond[6], o_auto_mode)
		end
		// controlled disable: input 7 active, then stop reported done
		level <= 8'h81;
		@(posedge o_sample_tick);
		repeat (4) @(posedge i_clk_sys);
		`CHK("cdis_qs", 1'b1, o_quickstop_req)
		`CHK("cdis_en0", 1'b1, o_drive_enable)
		apb(1, `DC_ADDR_CTRL, 32'h00010408);
		repeat (2) @(posedge i_clk_sys);
		`CHK("cdis_en1", 1'b0, o_drive_enable)
		level <= 8'h01;
		@(posedge o_sample_tick);
		repeat (4) @(posedge i_clk_sys);
		`CHK("cdis_en2", 1'b1, o_drive_enable)
		finish_test();
	end
endmodule

/* bench/din_cond_chk.sv */
// port assertions for the input conditioner
// bound to the top module, sees only its ports
`timescale 1ns/1ps
module din_cond_chk (
	input wire i_clk_sys,
	input wire i_resetn,
	input wire [7:0] i_din,
	input wire i_drive_enable_req,
	input wire i_psel,
	input wire i_penable,
	input wire o_pslverr,
	input wire o_drive_enable,
	input wire o_pos_limit,
	input wire o_quickstop_req,
	input wire o_decel_limit_en,
	input wire [7:0] o_func_strobe,
	input wire o_sample_tick
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	a_enable_cause: assert property (o_drive_enable |-> $past(i_din[0] & i_drive_enable_req))
		else $error("enable without cause");
	a_enable_drop: assert property (!i_din[0] |=> !o_drive_enable)
		else $error("enable held with input low");
	a_tick_pulse: assert property (o_sample_tick |=> !o_sample_tick [*8])
		else $error("tick too long");
	a_strobe_pulse: assert property (|o_func_strobe |=> o_func_strobe == 8'h00)
		else $error("strobe too long");
	a_strobe_tick: assert property (|o_func_strobe |-> o_sample_tick || $past(o_sample_tick) || $past(o_sample_tick, 2))
		else $error("strobe off tick");
	a_limit_tick: assert property ($changed(o_pos_limit) |-> o_sample_tick || $past(o_sample_tick) || $past(o_sample_tick, 2))
		else $error("limit changed off tick");
	a_qs_decel: assert property (o_decel_limit_en == o_quickstop_req)
		else $error("decel limit not with quickstop");
	a_err_access: assert property (o_pslverr |-> i_psel && i_penable)
		else $error("slave error outside access");
endmodule
bind digital_input_conditioner din_cond_chk chk_u (.i_clk_sys, .i_resetn, .i_din, .i_drive_enable_req, .i_psel,
	.i_penable, .o_pslverr, .o_drive_enable, .o_pos_limit, .o_quickstop_req, .o_decel_limit_en, .o_func_strobe,
	.o_sample_tick);

/* bench/din_switch_model.sv */
// switch bank model: eight field contacts in front of the conditioner
// assumes the bench sets the wanted contact levels
`timescale 1ns/1ps
module din_switch_model (
	input wire logic i_clk_sys,
	input wire logic [7:0] i_level,
	output logic [7:0] o_din
);
	initial o_din = 8'h00;
	always @(posedge i_clk_sys) o_din <= i_level;
endmodule

/* pkg/din_cond_consts.vh */
// constants for the digital input conditioner
// included by src/digital_input_conditioner.v
`ifndef DIN_COND_CONSTS_VH
`define DIN_COND_CONSTS_VH

`define DC_CLK_HZ 200000000
`define DC_SAMPLE_MS 2
`define DC_SAMPLE_CYC ((`DC_CLK_HZ / 1000) * `DC_SAMPLE_MS)

// register byte addresses
`define DC_ADDR_CTRL 12'h000
`define DC_ADDR_FUNC_LO 12'h004
`define DC_ADDR_FUNC_HI 12'h008
`define DC_ADDR_DEB_LO 12'h00C
`define DC_ADDR_DEB_HI 12'h010
`define DC_ADDR_STATUS 12'h014
`define DC_ADDR_QSDEC 12'h018

// ctrl fields
`define DC_CTRL_INV_LSB 0
`define DC_CTRL_LVL_LSB 8
`define DC_CTRL_QSDONE_BIT 16

// function codes, 4 bits per input, all eight in FUNC_LO; the HI register is not decoded
`define DC_FN_NONE 4'h0
`define DC_FN_BRAKE 4'h1
`define DC_FN_POSLIM 4'h2
`define DC_FN_NEGLIM 4'h3
`define DC_FN_HOME 4'h4
`define DC_FN_QSTOP 4'h5
`define DC_FN_AUTOMAN 4'h6
`define DC_FN_CDIS 4'h7

// reset values
`define DC_RST_FUNC 32'h00000000
`define DC_RST_DEB 32'h01010101
`define DC_RST_CTRL 32'h00000000
`define DC_RST_QSDEC 32'h000186A0

`endif

/* src/digital_input_conditioner.v */
// digital input conditioner: debounce, invert, trigger mode and function dispatch for eight inputs
// assumes inputs already synchronous to i_clk_sys; motion control consumes the dispatched strobes
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "din_cond_consts.vh"

module digital_input_conditioner (
	input wire i_clk_sys,
	input wire i_resetn,
	input wire [7:0] i_din,
	input wire i_drive_enable_req,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire o_pready,
	output wire o_pslverr,
	output reg [31:0] o_prdata,
	output reg o_drive_enable,
	output reg o_brake_release,
	output reg o_pos_limit,
	output reg o_neg_limit,
	output reg o_home_switch,
	output reg o_quickstop_req,
	output reg o_auto_mode,
	output reg o_decel_limit_en,
	output reg [31:0] o_decel_limit,
	output reg [7:0] o_func_strobe,
	output reg o_sample_tick
);
	reg [31:0] ctrl_r;
	reg [31:0] func_lo_r;
	reg [31:0] func_hi_r;
	reg [31:0] deb_lo_r;
	reg [31:0] deb_hi_r;
	reg [31:0] qsdec_r;
	reg [23:0] tick_cnt_r;
	reg [7:0] cond_r;
	reg [7:0] hold_r;
	reg [7:0] deb_cnt_r [0:7];
	reg cdis_latch_r;
	wire [63:0] func_all = {func_hi_r, func_lo_r};
	wire [63:0] deb_all = {deb_hi_r, deb_lo_r};
	wire [7:0] inv = ctrl_r[`DC_CTRL_INV_LSB +: 8];
	wire [7:0] lvl = ctrl_r[`DC_CTRL_LVL_LSB +: 8];
	wire qs_done = ctrl_r[`DC_CTRL_QSDONE_BIT];
	wire wr_en = i_psel & i_penable & i_pwrite;
	wire rd_en = i_psel & ~i_pwrite;
	wire mapped = (i_paddr == `DC_ADDR_CTRL) | (i_paddr == `DC_ADDR_FUNC_LO) |
		(i_paddr == `DC_ADDR_FUNC_HI) | (i_paddr == `DC_ADDR_DEB_LO) |
		(i_paddr == `DC_ADDR_DEB_HI) | (i_paddr == `DC_ADDR_STATUS) |
		(i_paddr == `DC_ADDR_QSDEC);
	// qs_done is written by motion control software after the stop
	wire [31:0] status = {8'h00, o_func_strobe, hold_r, cond_r};
	wire tick = (tick_cnt_r == (`DC_SAMPLE_CYC - 1));
	wire [7:0] raw_act = i_din ^ inv;
	reg [7:0] cond_nxt;
	reg [7:0] act_nxt;
	integer k;

	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~mapped;

	always @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			ctrl_r <= `DC_RST_CTRL;
			func_lo_r <= `DC_RST_FUNC;
			func_hi_r <= `DC_RST_FUNC;
			deb_lo_r <= `DC_RST_DEB;
			deb_hi_r <= `DC_RST_DEB;
			qsdec_r <= `DC_RST_QSDEC;
			o_prdata <= 32'h00000000;
		end else begin
			if (wr_en) begin
				case (i_paddr)
				`DC_ADDR_CTRL: ctrl_r <= i_pwdata;
				`DC_ADDR_FUNC_LO: func_lo_r <= i_pwdata;
				`DC_ADDR_FUNC_HI: func_hi_r <= i_pwdata;
				`DC_ADDR_DEB_LO: deb_lo_r <= i_pwdata;
				`DC_ADDR_DEB_HI: deb_hi_r <= i_pwdata;
				`DC_ADDR_QSDEC: qsdec_r <= i_pwdata;
				default: ;
				endcase
			end
			if (rd_en & ~i_penable) begin
				case (i_paddr)
				`DC_ADDR_CTRL: o_prdata <= ctrl_r;
				`DC_ADDR_FUNC_LO: o_prdata <= func_lo_r;
				`DC_ADDR_FUNC_HI: o_prdata <= func_hi_r;
				`DC_ADDR_DEB_LO: o_prdata <= deb_lo_r;
				`DC_ADDR_DEB_HI: o_prdata <= deb_hi_r;
				`DC_ADDR_STATUS: o_prdata <= status;
				`DC_ADDR_QSDEC: o_prdata <= qsdec_r;
				default: o_prdata <= 32'h00000000;
				endcase
			end
		end
	end

	always @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			tick_cnt_r <= 24'h000000;
			o_sample_tick <= 1'b0;
		end else begin
			tick_cnt_r <= tick ? 24'h000000 : tick_cnt_r + 24'h000001;
			o_sample_tick <= tick;
		end
	end

	// debounce compare; a count of zero acts as one
	always @* begin
		cond_nxt = cond_r;
		for (k = 0; k < 8; k = k + 1) begin
			if (!raw_act[k])
				cond_nxt[k] = 1'b0;
			// nine bits, so a saturated count cannot wrap to zero
			else if ({1'b0, deb_cnt_r[k]} + 9'h001 >= {1'b0, deb_all[k*8 +: 8]})
				cond_nxt[k] = 1'b1;
		end
	end

	always @* begin
		act_nxt = 8'h00;
		for (k = 0; k < 8; k = k + 1) begin
			if (lvl[k])
				act_nxt[k] = cond_nxt[k];
			else
				act_nxt[k] = cond_nxt[k] ^ cond_r[k];
		end
	end

	always @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			cond_r <= 8'h00;
			o_func_strobe <= 8'h00;
			for (k = 0; k < 8; k = k + 1)
				deb_cnt_r[k] <= 8'h00;
		end else if (tick) begin
			cond_r <= cond_nxt;
			o_func_strobe <= act_nxt;
			for (k = 0; k < 8; k = k + 1) begin
				if (!raw_act[k])
					deb_cnt_r[k] <= 8'h00;
				else if (deb_cnt_r[k] != 8'hFF)
					deb_cnt_r[k] <= deb_cnt_r[k] + 8'h01;
			end
		end else begin
			o_func_strobe <= 8'h00;
		end
	end

	// edge and level mode alike take the debounced state at each tick; the mode only shapes the strobes
	always @(posedge i_clk_sys) begin
		if (!i_resetn)
			hold_r <= 8'h00;
		else if (tick)
			hold_r <= cond_nxt;
	end

	reg brake_n, pl_n, nl_n, hm_n, qs_n, am_n, cd_n;
	always @* begin
		brake_n = 1'b0;
		pl_n = 1'b0;
		nl_n = 1'b0;
		hm_n = 1'b0;
		qs_n = 1'b0;
		am_n = 1'b0;
		cd_n = 1'b0;
		for (k = 0; k < 8; k = k + 1) begin
			case (func_all[k*4 +: 4])
			`DC_FN_BRAKE: brake_n = brake_n | hold_r[k];
			`DC_FN_POSLIM: pl_n = pl_n | hold_r[k];
			`DC_FN_NEGLIM: nl_n = nl_n | hold_r[k];
			`DC_FN_HOME: hm_n = hm_n | hold_r[k];
			`DC_FN_QSTOP: qs_n = qs_n | hold_r[k];
			`DC_FN_AUTOMAN: am_n = am_n | hold_r[k];
			`DC_FN_CDIS: cd_n = cd_n | hold_r[k];
			default: ;
			endcase
		end
	end

	always @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_drive_enable <= 1'b0;
			o_brake_release <= 1'b0;
			o_pos_limit <= 1'b0;
			o_neg_limit <= 1'b0;
			o_home_switch <= 1'b0;
			o_quickstop_req <= 1'b0;
			o_auto_mode <= 1'b0;
			o_decel_limit_en <= 1'b0;
			o_decel_limit <= 32'h00000000;
			cdis_latch_r <= 1'b0;
		end else begin
			// disable held until the controlled-disable input drops
			if (!cd_n)
				cdis_latch_r <= 1'b0;
			else if (qs_done)
				cdis_latch_r <= 1'b1;
			// raw input 0 gates the enable, not debounced
			o_drive_enable <= i_din[0] & i_drive_enable_req & ~cdis_latch_r;
			o_brake_release <= brake_n;
			o_pos_limit <= pl_n;
			o_neg_limit <= nl_n;
			o_home_switch <= hm_n;
			o_quickstop_req <= qs_n | cd_n;
			o_auto_mode <= am_n;
			o_decel_limit_en <= qs_n | cd_n;
			o_decel_limit <= qsdec_r;
		end
	end

endmodule
